// File: verilog/flash_bus_host.sv
/*
 * Host sequencer for an asynchronous parallel flash bus: reads, writes,
 * signature reads, protect/unprotect pulses, verify reads and reset.
 * Assumes the flash answers within one strobe window and that the board
 * converts the raised qualifiers into high-voltage pin levels.
 */
// Flash bus rules that this block works to
// R1 - Read data is sampled only while chip select and output enable are low.
// R2 - Writes hold chip select and write strobe low with output enable high.
// R3 - Device latches address at the later falling strobe edge.
// R4 - Device latches data at the first rising strobe edge.
// R5 - Device floats data while output enable and write strobe are high.
// R6 - Chip select high with idle controller means standby, outputs floating.
// R7 - Device enters pseudo-standby after 150ns bus inactivity, still driving.
// R8 - Raised signature pin, A1 low: A0 selects maker or part code.
// R9 - After auto-select codes read without raised voltage; upper byte 00h.
// R10 - Protect: raise signature and output enable, pulse write low 100us.
// R11 - Protect verify read with A1 high, A0 and A6 low returns 01h.
// R12 - Device ignores program or erase to protected blocks.
// R13 - After auto-select, protection read returns 01h or 00h.
// R14 - Raised reset pin temporarily unprotects all blocks.
// R15 - Unprotect: raise signature, OE, CS, A12 and A15 high, 10ms pulse.
// R16 - Host protects every block before global unprotection.
// R17 - Unprotect verify with A6 and A1 high returns 00h.
// R18 - Host verifies each block separately after unprotection.
// R19 - Reset pin low at least 500ns; ready 50ns after release.
// R20 - Byte mode uses low byte and top data pin as address LSB.
// R21 - Raised levels are separate qualifier outputs, not logic high.
`default_nettype none
module flash_bus_host
   import flash_host_pkg::*;
#(
   parameter int PROTECT_CYCLES = PROTECT_CYC,
   parameter int UNPROTECT_CYCLES = UNPROTECT_CYC
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic REQ_VALID,
   input wire host_req_t REQ,
   output logic REQ_READY,
   output logic RSP_VALID,
   output logic [DATA_W-1:0] RSP_DATA,
   output bus_ctl_t BUS_CTL,
   output logic [ADDR_W-1:0] ADDR,
   output logic [DATA_W-1:0] DQ_OUT,
   output logic [DATA_W-1:0] DQ_OE,
   input wire logic [DATA_W-1:0] DQ_IN
);
   /***********************************************
    * Pin input synchroniser
    ***********************************************/
   logic [DATA_W-1:0] dq_s1_r, dq_s2_r, dq_s3_r;
   always_ff @(posedge CLK) begin
      dq_s1_r <= DQ_IN;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
   end
   wire logic dq_stable = (dq_s2_r == dq_s3_r);

   /***********************************************
    * Sequencer
    ***********************************************/
   typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_RST_LOW, S_RST_WAIT} state_t;
   state_t state_r, state_nxt;
   host_req_t req_r;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   bus_ctl_t ctl_r, ctl_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [DATA_W-1:0] dqo_r, dqo_nxt, dqoe_r, dqoe_nxt, rdata_r, rdata_nxt;
   logic rsp_r, rsp_nxt, ready_r, ready_nxt;

   wire logic is_write = (req_r.op == OP_WRITE);
   wire logic is_read = (req_r.op == OP_READ) || (req_r.op == OP_SIG_READ) ||
                        (req_r.op == OP_PROT_VERIFY) || (req_r.op == OP_UNPROT_VERIFY);
   wire logic is_pulse = (req_r.op == OP_PROTECT) || (req_r.op == OP_UNPROTECT);
   // Reads stretch the strobe by the synchroniser depth, otherwise the idle bus level is sampled.
   wire logic [CNT_W-1:0] strobe_len = (req_r.op == OP_PROTECT) ? CNT_W'(PROTECT_CYCLES) :
                                       (req_r.op == OP_UNPROTECT) ? CNT_W'(UNPROTECT_CYCLES) :
                                       is_read ? CNT_W'(STROBE_CYC + SYNC_CYC) :
                                       CNT_W'(STROBE_CYC);
   // R20 byte addressing: top data pin carries the address LSB in byte mode.
   wire logic lsb_drive = req_r.byte_mode;
   wire logic [DATA_W-1:0] lsb_mask = lsb_drive ? 16'h8000 : 16'h0000;
   wire logic [DATA_W-1:0] lsb_val = (lsb_drive && req_r.addr_lsb) ? 16'h8000 : 16'h0000;
   // R9 byte-wide reads keep only the low byte; the upper lines float except the top data pin, which the host drives with the address LSB.
   wire logic [DATA_W-1:0] rd_mask = req_r.byte_mode ? 16'h00FF : 16'hFFFF;
   // R8 R11 R17 special addresses force the selector bits of each verify.
   logic [ADDR_W-1:0] spec_addr;
   always_comb begin
      spec_addr = req_r.addr;
      unique case (req_r.op)
         OP_SIG_READ: spec_addr[A1_POS] = 1'b0;
         OP_PROT_VERIFY: begin
            spec_addr[A0_POS] = 1'b0;
            spec_addr[A1_POS] = 1'b1;
            spec_addr[A6_POS] = 1'b0;
         end
         OP_UNPROT_VERIFY: begin
            spec_addr[A0_POS] = 1'b0;
            spec_addr[A1_POS] = 1'b1;
            spec_addr[A6_POS] = 1'b1;
         end
         // R15 global unprotect needs A12 and A15 high.
         // R16 R18 requesters protect all blocks first, then verify each block alone.
         OP_UNPROTECT: begin
            spec_addr[A12_POS] = 1'b1;
            spec_addr[A15_POS] = 1'b1;
         end
         default: spec_addr = req_r.addr;
      endcase
   end
   wire logic sig_mode = (req_r.op != OP_READ) && (req_r.op != OP_WRITE) && (req_r.op != OP_RESET);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      ctl_nxt = ctl_r;
      addr_nxt = addr_r;
      dqo_nxt = dqo_r;
      dqoe_nxt = dqoe_r;
      rdata_nxt = rdata_r;
      rsp_nxt = 1'b0;
      ready_nxt = 1'b0;
      unique case (state_r)
         S_IDLE: begin
            ready_nxt = 1'b1;
            if (REQ_VALID && ready_r) begin
               ready_nxt = 1'b0;
               state_nxt = (REQ.op == OP_RESET) ? S_RST_LOW : S_SETUP;
               cnt_nxt = '0;
            end
         end
         S_SETUP: begin
            // R3 address and qualifiers settle before any strobe falls.
            addr_nxt = spec_addr;
            ctl_nxt.word_mode = ~req_r.byte_mode;
            // R21 raised levels are their own qualifier outputs.
            ctl_nxt.sig_raised = sig_mode;
            ctl_nxt.oe_raised = is_pulse;
            ctl_nxt.cs_raised = (req_r.op == OP_UNPROTECT);
            dqo_nxt = is_write ? ((req_r.wdata & ~lsb_mask) | lsb_val) : lsb_val;
            dqoe_nxt = is_write ? (req_r.byte_mode ? 16'h80FF : 16'hFFFF) : lsb_mask;
            // R2 writes keep output enable high.
            ctl_nxt.out_en_n = 1'b1;
            state_nxt = S_STROBE;
            cnt_nxt = '0;
         end
         S_STROBE: begin
            // R2 R10 assert chip select and the selected strobe together; R15 unprotect holds chip select high.
            ctl_nxt.chip_sel_n = (req_r.op == OP_UNPROTECT) ? 1'b1 : 1'b0;
            ctl_nxt.write_n = ~(is_write || is_pulse);
            // R1 reads drop output enable only with chip select low.
            ctl_nxt.out_en_n = ~is_read;
            cnt_nxt = cnt_r + CNT_W'(1);
            if (cnt_r >= strobe_len) begin
               // R4 the write strobe rises first so data latches while chip select holds.
               ctl_nxt.write_n = 1'b1;
               // R1 sample only inside the chip select and output enable window.
               if (!is_read || dq_stable) begin
                  rdata_nxt = dq_s3_r & rd_mask;
                  state_nxt = S_HOLD;
               end
            end
         end
         S_HOLD: begin
            // R5 R6 return to standby so the device floats its outputs.
            ctl_nxt.out_en_n = 1'b1;
            ctl_nxt.chip_sel_n = 1'b1;
            ctl_nxt.sig_raised = 1'b0;
            ctl_nxt.oe_raised = 1'b0;
            ctl_nxt.cs_raised = 1'b0;
            dqoe_nxt = '0;
            rsp_nxt = 1'b1;
            state_nxt = S_IDLE;
         end
         S_RST_LOW: begin
            // R19 hold the reset pin low for the least pulse width.
            ctl_nxt.reset_unprotect_n = 1'b0;
            ctl_nxt.rst_raised = 1'b0;
            dqoe_nxt = '0;
            cnt_nxt = cnt_r + CNT_W'(1);
            if (cnt_r >= CNT_W'(RESET_LOW_CYC)) begin
               ctl_nxt.reset_unprotect_n = 1'b1;
               cnt_nxt = '0;
               state_nxt = S_RST_WAIT;
            end
         end
         S_RST_WAIT: begin
            // R19 wait out the recovery time after the rising edge.
            cnt_nxt = cnt_r + CNT_W'(1);
            if (cnt_r >= CNT_W'(RESET_RECOVER_CYC)) begin
               // R14 a reset request may leave temporary unprotection raised.
               ctl_nxt.rst_raised = req_r.wdata[0];
               rsp_nxt = 1'b1;
               state_nxt = S_IDLE;
            end
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_r <= S_IDLE;
         req_r <= '0;
         cnt_r <= '0;
         ctl_r <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1, reset_unprotect_n: 1'b1,
                    word_mode: 1'b1, default: 1'b0};
         addr_r <= ADDR_RESET;
         dqo_r <= DATA_RESET;
         dqoe_r <= DATA_RESET;
         rdata_r <= DATA_RESET;
         rsp_r <= 1'b0;
         ready_r <= 1'b0;
      end else begin
         if (state_r == S_IDLE && REQ_VALID && ready_r) begin
            req_r <= REQ;
         end
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         ctl_r <= ctl_nxt;
         addr_r <= addr_nxt;
         dqo_r <= dqo_nxt;
         dqoe_r <= dqoe_nxt;
         rdata_r <= rdata_nxt;
         rsp_r <= rsp_nxt;
         ready_r <= ready_nxt;
      end
   end

   assign REQ_READY = ready_r;
   assign RSP_VALID = rsp_r;
   assign RSP_DATA = rdata_r;
   assign BUS_CTL = ctl_r;
   assign ADDR = addr_r;
   assign DQ_OUT = dqo_r;
   assign DQ_OE = dqoe_r;
endmodule
`default_nettype wire

// File: verilog/flash_host_pkg.sv
/*
 * Shared constants and carrier types for the parallel flash bus host.
 * Assumes a 10 MHz system clock and a board that turns the qualifier
 * outputs into raised-voltage pin levels.
 */
`default_nettype none
package flash_host_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 16;
   // Timing figures in their own units.
   localparam int T_RESET_LOW_NS = 500;
   localparam int T_RESET_RECOVER_NS = 50;
   localparam int T_PROTECT_US = 100;
   localparam int T_UNPROTECT_MS = 10;
   localparam int T_STROBE_NS = 100;
   // Cycle counts, least times rounded up.
   localparam int RESET_LOW_CYC = (T_RESET_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int RESET_RECOVER_CYC_RAW = (T_RESET_RECOVER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int RESET_RECOVER_CYC = (RESET_RECOVER_CYC_RAW < 1) ? 1 : RESET_RECOVER_CYC_RAW;
   localparam int STROBE_CYC = (T_STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // Read data crosses the pin synchroniser before it can be sampled.
   localparam int SYNC_CYC = 3;
   localparam int PROTECT_CYC = T_PROTECT_US * (CLK_HZ / 1_000_000);
   localparam int UNPROTECT_CYC = T_UNPROTECT_MS * (CLK_HZ / 1_000);
   localparam int CNT_W = 24;
   // Address bit positions used by the special modes.
   localparam int A0_POS = 0;
   localparam int A1_POS = 1;
   localparam int A6_POS = 6;
   localparam int A12_POS = 12;
   localparam int A15_POS = 15;
   localparam int BLK_LSB = 12;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h0_0000;

   typedef enum logic [2:0] {
      OP_READ, OP_WRITE, OP_SIG_READ, OP_PROT_VERIFY, OP_UNPROT_VERIFY,
      OP_PROTECT, OP_UNPROTECT, OP_RESET
   } op_t;

   typedef struct packed {
      op_t op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic byte_mode;
      logic addr_lsb;
   } host_req_t;

   // Pin qualifiers: raised-voltage levels are separate from logic high.
   typedef struct packed {
      logic chip_sel_n;
      logic out_en_n;
      logic write_n;
      logic reset_unprotect_n;
      logic word_mode;
      logic sig_raised;
      logic oe_raised;
      logic cs_raised;
      logic rst_raised;
   } bus_ctl_t;
endpackage
`default_nettype wire

// File: dv/flash_bus_host_chk.sv
/* Pin-level checks for the flash bus host.
   Assumes it is bound to flash_bus_host and sees only its ports. */
`default_nettype none
module flash_bus_host_chk
   import flash_host_pkg::*;
#(
   parameter int PROTECT_CYCLES = PROTECT_CYC,
   parameter int UNPROTECT_CYCLES = UNPROTECT_CYC
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic REQ_READY,
   input wire logic RSP_VALID,
   input wire bus_ctl_t BUS_CTL,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] DQ_OE
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // Strobe counters and properties
   // ****
   logic [23:0] wlo_r, wlo_nxt, rlo_r, rlo_nxt;
   assign wlo_nxt = BUS_CTL.write_n ? 24'h00_0000 : wlo_r + 24'h00_0001;
   assign rlo_nxt = BUS_CTL.reset_unprotect_n ? 24'h00_0000 : rlo_r + 24'h00_0001;
   always_ff @(posedge CLK) begin
      wlo_r <= RESET ? 24'h00_0000 : wlo_nxt;
      rlo_r <= RESET ? 24'h00_0000 : rlo_nxt;
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);
   sequence s_wr_low;
      !BUS_CTL.write_n ##1 !BUS_CTL.write_n;
   endsequence
   sequence s_strobe_end;
      !BUS_CTL.write_n ##1 BUS_CTL.write_n;
   endsequence
   a_reset_idle_bus: assert property (@(posedge CLK) disable iff (1'b0)
      RESET |=> !REQ_READY && BUS_CTL.chip_sel_n && BUS_CTL.write_n && DQ_OE == 16'h0000)
      else $error("bus not idle after reset");
   a_rsp_one_pulse: assert property (RSP_VALID |=> !RSP_VALID && REQ_READY)
      else $error("response pulse or ready wrong");
   a_read_no_drive: assert property (!BUS_CTL.out_en_n |-> BUS_CTL.write_n && DQ_OE[7:0] == 8'h00)
      else $error("host drives data during read");
   a_write_oe_high: assert property (!BUS_CTL.write_n && !BUS_CTL.chip_sel_n |->
      BUS_CTL.out_en_n && (BUS_CTL.oe_raised || DQ_OE[7:0] == 8'hFF))
      else $error("write cycle malformed");
   a_addr_hold: assert property (s_wr_low |-> $stable(ADDR) && $stable(BUS_CTL.chip_sel_n))
      else $error("address moved during strobe");
   a_protect_width: assert property (s_strobe_end ##0 BUS_CTL.oe_raised |-> wlo_r >= PROTECT_CYCLES)
      else $error("protect pulse too short");
   a_unprot_width: assert property (s_strobe_end ##0 BUS_CTL.cs_raised |-> wlo_r >= UNPROTECT_CYCLES)
      else $error("unprotect pulse too short");
   a_protect_setup: assert property (!BUS_CTL.write_n && BUS_CTL.oe_raised |-> BUS_CTL.sig_raised)
      else $error("protect without signature level");
   a_unprot_setup: assert property (!BUS_CTL.write_n && BUS_CTL.cs_raised |->
      BUS_CTL.oe_raised && BUS_CTL.sig_raised && ADDR[15] && ADDR[12])
      else $error("unprotect setup wrong");
   a_verify_addr: assert property (!BUS_CTL.out_en_n && BUS_CTL.sig_raised && ADDR[1] |-> !ADDR[0])
      else $error("verify read address wrong");
   a_reset_width: assert property ($rose(BUS_CTL.reset_unprotect_n) |-> rlo_r >= RESET_LOW_CYC)
      else $error("reset pulse too short");
endmodule
bind flash_bus_host flash_bus_host_chk #(
   .PROTECT_CYCLES(PROTECT_CYCLES),
   .UNPROTECT_CYCLES(UNPROTECT_CYCLES)
) u_flash_bus_host_chk (
   .CLK(CLK), .RESET(RESET), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
   .BUS_CTL(BUS_CTL), .ADDR(ADDR), .DQ_OE(DQ_OE)
);
`default_nettype wire

// File: dv/flash_dev_model.sv
/* Behavioural flash device seen from its pins.
   Assumes raised-voltage levels arrive as separate qualifier bits. */
`default_nettype none
module flash_dev_model
   import flash_host_pkg::*;
#(
   parameter int PROT_NS = 100_000,
   parameter int UNPROT_NS = 10_000_000,
   // Identity values are arbitrary.
   parameter logic [7:0] MAKER_CODE = 8'h5A,
   parameter logic [7:0] PART_CODE = 8'h6C
) (
   input wire bus_ctl_t ctl,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic [DATA_W-1:0] dq_oe,
   output logic [DATA_W-1:0] dq_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:15];
   logic [31:0] prot;
   logic [15:0] last_q, rd, dev;
   logic [17:0] lat_a;
   logic drive, wr_act;
   time t_fall;
   // ****
   // Pin behaviour
   // ****
   // Released lines show the inverse of the last value, so stale data never passes.
   assign dq_in = (dq_oe & dq_out) | (~dq_oe & dev);
   assign drive = !ctl.chip_sel_n && !ctl.out_en_n && ctl.write_n && ctl.reset_unprotect_n && !ctl.oe_raised;
   assign wr_act = !ctl.chip_sel_n && !ctl.write_n && ctl.out_en_n && !ctl.oe_raised && !ctl.cs_raised;
   assign rd = ctl.sig_raised ? (addr[1] ? {15'h0000, prot[addr[16:12]]} : {8'h00, addr[0] ? PART_CODE : MAKER_CODE})
      : ctl.word_mode ? mem[addr[3:0]] : {8'h00, dq_out[15] ? mem[addr[3:0]][15:8] : mem[addr[3:0]][7:0]};
   assign dev = !drive ? ~last_q : ctl.word_mode ? rd : {~last_q[15:8], rd[7:0]};
   always @(drive, rd)
      if (drive)
         last_q = rd;
   initial begin
      prot = '0;
      last_q = '0;
      for (int i = 0; i < 16; i++)
         mem[i] = 16'hFFFF;
   end
   always @(posedge wr_act)
      lat_a = {addr, dq_out[15]};
   always @(negedge wr_act)
      if (!prot[lat_a[17:13]] || ctl.rst_raised) begin
         if (ctl.word_mode)
            mem[lat_a[4:1]] = dq_out;
         else if (lat_a[0])
            mem[lat_a[4:1]][15:8] = dq_out[7:0];
         else
            mem[lat_a[4:1]][7:0] = dq_out[7:0];
      end
   always @(negedge ctl.write_n)
      t_fall = $time;
   always @(posedge ctl.write_n)
      if (ctl.sig_raised && ctl.oe_raised && ctl.cs_raised && addr[12] && addr[15]) begin
         if (&prot && $time - t_fall >= UNPROT_NS)
            prot = '0;
      end else if (ctl.sig_raised && ctl.oe_raised && $time - t_fall >= PROT_NS)
         prot[addr[16:12]] = 1'b1;
endmodule
`default_nettype wire

// File: dv/test_flash_bus_host.sv
/* Self-checking bench for flash_bus_host against the flash model.
   Assumes package, model and checker are compiled first. */
`default_nettype none
module test_flash_bus_host
   import flash_host_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PCYC = 10;
   localparam int UCYC = 20;
   // Identity values are arbitrary.
   localparam logic [7:0] MAKER = 8'h5A;
   localparam logic [7:0] PART = 8'h6C;
   logic clk, rst, req_valid, req_ready, rsp_valid;
   host_req_t req;
   logic [DATA_W-1:0] rsp_data, dq_out, dq_oe, dq_in;
   logic [ADDR_W-1:0] addr;
   bus_ctl_t bus_ctl;
   int failures, compares;
   flash_bus_host #(.PROTECT_CYCLES(PCYC), .UNPROTECT_CYCLES(UCYC)) u_flash_bus_host (
      .CLK(clk), .RESET(rst), .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
      .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .BUS_CTL(bus_ctl), .ADDR(addr),
      .DQ_OUT(dq_out), .DQ_OE(dq_oe), .DQ_IN(dq_in));
   flash_dev_model #(.PROT_NS(PCYC * 100), .UNPROT_NS(UCYC * 100), .MAKER_CODE(MAKER),
      .PART_CODE(PART)) u_flash_dev_model (
      .ctl(bus_ctl), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
   // ****
   // Tasks and scenarios
   // ****
   task automatic chk(input string nm, input logic [15:0] exp);
      compares++;
      if (rsp_data !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, rsp_data);
      end
   endtask
   task automatic op(input op_t o, input logic [16:0] a, input logic [15:0] d,
      input logic bm = 1'b0, input logic lsb = 1'b0);
      int n;
      req = '{o, a, d, bm, lsb};
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(posedge clk) #1;
         n++;
      end
      @(posedge clk) #1;
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 300) begin
         @(posedge clk) #1;
         n++;
      end
      if (rsp_valid !== 1'b1) begin
         failures++;
         $display("[FAIL] response expected 1 seen %b", rsp_valid);
      end
   endtask
   task automatic t_write_read();
      op(OP_WRITE, 17'h0_0003, 16'h1234);
      op(OP_WRITE, 17'h0_0004, 16'hBEEF);
      op(OP_READ, 17'h0_0003, 16'h0000);
      chk("word 3", 16'h1234);
      op(OP_READ, 17'h0_0004, 16'h0000);
      chk("word 4", 16'hBEEF);
   endtask
   task automatic t_byte();
      op(OP_WRITE, 17'h0_0005, 16'hA5C3);
      op(OP_READ, 17'h0_0005, 16'h0000, 1'b1, 1'b0);
      chk("byte lo", 16'h00C3);
      op(OP_READ, 17'h0_0005, 16'h0000, 1'b1, 1'b1);
      chk("byte hi", 16'h00A5);
      op(OP_WRITE, 17'h0_0006, 16'h0077, 1'b1, 1'b1);
      op(OP_READ, 17'h0_0006, 16'h0000);
      chk("byte write", 16'h77FF);
   endtask
   task automatic t_sig();
      op(OP_SIG_READ, 17'h1_F0FC, 16'h0000);
      chk("maker", {8'h00, MAKER});
      op(OP_SIG_READ, 17'h0_0001, 16'h0000);
      chk("part", {8'h00, PART});
   endtask
   task automatic t_protect();
      op(OP_PROTECT, 17'h1_0000, 16'h0000);
      op(OP_PROT_VERIFY, 17'h1_0000, 16'h0000);
      chk("blk 16 locked", 16'h0001);
      op(OP_PROT_VERIFY, 17'h0_8000, 16'h0000);
      chk("blk 8 open", 16'h0000);
      op(OP_WRITE, 17'h1_0002, 16'h5A5A);
      op(OP_READ, 17'h1_0002, 16'h0000);
      chk("locked write", 16'hFFFF);
      op(OP_RESET, 17'h0_0000, 16'h0001);
      op(OP_WRITE, 17'h1_0002, 16'h5A5A);
      op(OP_READ, 17'h1_0002, 16'h0000);
      chk("temp open", 16'h5A5A);
      op(OP_RESET, 17'h0_0000, 16'h0000);
      op(OP_WRITE, 17'h1_0002, 16'h0F0F);
      op(OP_READ, 17'h1_0002, 16'h0000);
      chk("relocked", 16'h5A5A);
   endtask
   task automatic t_unprotect();
      for (int b = 0; b < 32; b++)
         op(OP_PROTECT, {b[4:0], 12'h000}, 16'h0000);
      op(OP_PROT_VERIFY, 17'h1_F000, 16'h0000);
      chk("blk 31 locked", 16'h0001);
      op(OP_UNPROTECT, 17'h0_0000, 16'h0000);
      for (int b = 0; b < 32; b++) begin
         op(OP_UNPROT_VERIFY, {b[4:0], 12'h000}, 16'h0000);
         chk("unprotected", 16'h0000);
      end
   endtask
   task automatic close_out();
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      failures = 0;
      compares = 0;
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      t_write_read();
      t_byte();
      t_sig();
      t_protect();
      t_unprotect();
      close_out();
   end
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      close_out();
   end
endmodule
`default_nettype wire
